// File: hdl/pad_function_config.v
// pad function, pull, hysteresis, drain and input location configuration for all port pins
//
// Notes on behaviour
// [RULE_01] function code 000 in bits 2:0 routes the pin to gpio, other defined codes to a peripheral.
// [RULE_02] a pin in gpio function takes its direction from its bit of the gpio direction register.
// [RULE_03] with a peripheral function the peripheral drives the direction and the gpio direction is ignored.
// [RULE_04] pull field bits 4:3 select none 00, pull-down 01, pull-up 10, repeater 11.
// [RULE_05] after reset each pull field except those of the two i2c pins holds the pull-up setting.
// [RULE_06] repeater mode enables pull-up while the pin reads high and pull-down while it reads low.
// [RULE_07] the repeater retention need not hold during deep power-down.
// [RULE_08] bit 5 enables the input hysteresis buffer when 1, resets to 0.
// [RULE_09] the two i2c pins in i2c function offer standard/fast filtered, fast-plus sink, or plain open-drain.
// [RULE_10] software picks standard/fast or plain io mode when an i2c pin is used as gpio.
// [RULE_11] bit 10 set turns an output pin into open-drain, clear keeps push-pull.
// [RULE_12] the open-drain bit has no effect on the primary i2c pins.
// [RULE_13] every port pin has exactly one configuration register.
// [RULE_14] the serial clock input takes its source from the pin named by the location register, reset 0.
// [RULE_15] the two i2c pin registers reset to 0x00, all other pin registers to 0xd0.
// [RULE_16] port 2 pin 0 selects gpio 000, modem terminal-ready 001, second ssp slave select 010, rest reserved.
// [RULE_17] reserved bits and unassigned offsets ignore writes and read their reset value or zero.
`timescale 1ns/100ps
`include "pad_config_consts.vh"
`default_nettype none

module pad_function_config (
	input  wire        core_clk_i,             // 100 mhz system clock
	input  wire        rst_b_i,                // async reset, active low
	input  wire [11:0] reg_addr_i,             // byte offset into configuration space
	input  wire [31:0] reg_wdata_i,            // write data
	input  wire        reg_wr_i,               // write strobe
	input  wire        reg_rd_i,               // read strobe
	output reg  [31:0] reg_rdata_o,            // read data, cycle after strobe
	input  wire [24:0] port_direction_reg_i,   // gpio direction per pin, 1 = output
	input  wire [24:0] gpio_out_i,             // gpio output level per pin
	output reg  [24:0] gpio_in_o,              // synchronised pad level toward gpio
	input  wire [24:0] alt1_out_i,             // peripheral output for function 001
	input  wire [24:0] alt1_oe_i,              // peripheral drive enable for function 001
	input  wire [24:0] alt2_out_i,             // peripheral output for function 010
	input  wire [24:0] alt2_oe_i,              // peripheral drive enable for function 010
	output reg  [24:0] periph_in_o,            // synchronised pad level toward peripherals
	output reg         ssp_serial_clock_input_o, // serial clock from the selected location
	input  wire [24:0] pad_in_i,               // raw pad level
	output reg  [24:0] pad_out_o,              // pad output level
	output reg  [24:0] pad_oe_o,               // pad output enable, high while driving
	output reg  [24:0] pull_up_en_o,           // pull-up resistor enable
	output reg  [24:0] pull_dn_en_o,           // pull-down resistor enable
	output reg  [24:0] input_schmitt_enable_o, // hysteresis buffer enable
	output reg  [1:0]  i2c_filter_en_o,        // glitch filter on i2c clock/data pads
	output reg  [1:0]  i2c_high_sink_o,        // fast-plus high current sink on i2c pads
	input  wire        deep_powerdown_i        // deep power-down request level
);

	reg        rst_meta_ff;
	reg        rst_b_ff;
	reg [10:0] cfg_ff [0:24];
	reg [1:0]  sck_loc_ff;
	reg [24:0] pad_meta_ff;
	reg [24:0] pad_sync_ff;
	reg        dpd_meta_ff;
	reg        dpd_sync_ff;
	reg [4:0]  wr_idx;
	reg [4:0]  rd_idx;
	reg [31:0] nxt_rdata;
	reg [24:0] nxt_pad_out;
	reg [24:0] nxt_pad_oe;
	reg [24:0] nxt_pull_up;
	reg [24:0] nxt_pull_dn;
	reg [24:0] nxt_schmitt;
	reg [1:0]  nxt_i2c_filter;
	reg [1:0]  nxt_i2c_sink;
	reg        nxt_sck;
	integer    i;
	integer    r;  // reset loop index, kept apart from the steering loop's index
	// one register per pin, position in the array is the pin index
	function [4:0] pin_of_addr;
		input [11:0] a;
		begin
			case (a)
				`OFS_PAD_CFG_RESET_PORT0_PIN0:  pin_of_addr = 5'd0;   // see [RULE_13]
				`OFS_PAD_CFG_PORT0_PIN1:        pin_of_addr = 5'd1;
				`OFS_PAD_CFG_PORT0_PIN2:        pin_of_addr = 5'd2;
				`OFS_PAD_CFG_PORT0_PIN3:        pin_of_addr = 5'd3;
				`OFS_PAD_CFG_PORT0_PIN4:        pin_of_addr = 5'd4;
				`OFS_PAD_CFG_PORT0_PIN5:        pin_of_addr = 5'd5;
				`OFS_PAD_CFG_PORT0_PIN6:        pin_of_addr = 5'd6;
				`OFS_PAD_CFG_PORT0_PIN7:        pin_of_addr = 5'd7;
				`OFS_PAD_CFG_PORT0_PIN8:        pin_of_addr = 5'd8;
				`OFS_PAD_CFG_PORT0_PIN9:        pin_of_addr = 5'd9;
				`OFS_PAD_CFG_DEBUGCLK_P0_PIN10: pin_of_addr = 5'd10;
				`OFS_PAD_CFG_PORT1_PIN1:        pin_of_addr = 5'd11;
				`OFS_PAD_CFG_PORT1_PIN2:        pin_of_addr = 5'd12;
				`OFS_PAD_CFG_DEBUGIO_P1_PIN3:   pin_of_addr = 5'd13;
				`OFS_PAD_CFG_PORT1_PIN4:        pin_of_addr = 5'd14;
				`OFS_PAD_CFG_PORT1_PIN5:        pin_of_addr = 5'd15;
				`OFS_PAD_CFG_PORT1_PIN6:        pin_of_addr = 5'd16;
				`OFS_PAD_CFG_PORT1_PIN7:        pin_of_addr = 5'd17;
				`OFS_PAD_CFG_PORT1_PIN8:        pin_of_addr = 5'd18;
				`OFS_PAD_CFG_PORT1_PIN9:        pin_of_addr = 5'd19;
				`OFS_PAD_CFG_PORT1_PIN11:       pin_of_addr = 5'd20;
				`OFS_PAD_CFG_PORT2_PIN0:        pin_of_addr = 5'd21;
				`OFS_PAD_CFG_PORT3_PIN2:        pin_of_addr = 5'd22;
				`OFS_PAD_CFG_PORT3_PIN4:        pin_of_addr = 5'd23;
				`OFS_PAD_CFG_PORT3_PIN5:        pin_of_addr = 5'd24;
				default:                        pin_of_addr = `PIN_NONE;
			endcase
		end
	endfunction

	function is_i2c_pin;
		input [4:0] p;
		begin
			is_i2c_pin = (p == `PIN_P0_4) || (p == `PIN_P0_5);
		end
	endfunction

	// reset release through two flops so all flops leave reset on the same edge
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_ff <= 1'b0;
			rst_b_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_b_ff    <= rst_meta_ff;
		end
	end

	// pad levels and power-down arrive from outside the clock domain
	always @(posedge core_clk_i or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			pad_meta_ff <= 25'h0000000;
			pad_sync_ff <= 25'h0000000;
			dpd_meta_ff <= 1'b0;
			dpd_sync_ff <= 1'b0;
		end else begin
			pad_meta_ff <= pad_in_i;
			pad_sync_ff <= pad_meta_ff;
			dpd_meta_ff <= deep_powerdown_i;
			dpd_sync_ff <= dpd_meta_ff;
		end
	end

	always @* begin
		wr_idx = pin_of_addr(reg_addr_i);
		rd_idx = pin_of_addr(reg_addr_i);
	end

	// register writes; only defined fields take the write data
	always @(posedge core_clk_i or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			for (r = 0; r < `PAD_NUM_PINS; r = r + 1) begin
				if (r == 4 || r == 5) begin
					cfg_ff[r] <= `RST_PAD_CFG_I2C;   // see [RULE_15]
				end else begin
					cfg_ff[r] <= `RST_PAD_CFG;       // see [RULE_05] see [RULE_15]
				end
			end
			sck_loc_ff <= `RST_SCK_LOC;              // see [RULE_14]
		end else if (reg_wr_i) begin
			if (wr_idx != `PIN_NONE) begin
				if (is_i2c_pin(wr_idx)) begin
					cfg_ff[wr_idx] <= (reg_wdata_i[10:0] & `WR_MASK_PAD_CFG_I2C) |
					                  (`RST_PAD_CFG_I2C & ~`WR_MASK_PAD_CFG_I2C);
				end else begin
					// reserved bits 9:6 keep their reset pattern
					cfg_ff[wr_idx] <= (reg_wdata_i[10:0] & `WR_MASK_PAD_CFG) |
					                  (`RST_PAD_CFG & ~`WR_MASK_PAD_CFG);   // see [RULE_17]
				end
			end else if (reg_addr_i == `OFS_SERIAL_CLOCK_LOC_SELECT) begin
				sck_loc_ff <= reg_wdata_i[1:0];
			end
		end
	end

	// read path; reserved slots and unmapped offsets answer zero
	always @* begin
		nxt_rdata = 32'h00000000;                   // see [RULE_17]
		if (rd_idx != `PIN_NONE) begin
			nxt_rdata = {21'h000000, cfg_ff[rd_idx]};
		end else if (reg_addr_i == `OFS_SERIAL_CLOCK_LOC_SELECT) begin
			nxt_rdata = {30'h00000000, sck_loc_ff};
		end
	end

	always @(posedge core_clk_i or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= nxt_rdata;
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// per-pin pad steering
	always @* begin : pad_steer
		reg [2:0] role;
		reg [1:0] pull;
		reg [1:0] i2c_mode;
		reg       drv;
		reg       oe;
		reg       i2c_fn;
		role     = 3'h0;
		pull     = 2'h0;
		i2c_mode = 2'h0;
		drv      = 1'b0;
		oe       = 1'b0;
		i2c_fn   = 1'b0;
		nxt_pad_out    = 25'h0000000;
		nxt_pad_oe     = 25'h0000000;
		nxt_pull_up    = 25'h0000000;
		nxt_pull_dn    = 25'h0000000;
		nxt_schmitt    = 25'h0000000;
		nxt_i2c_filter = 2'h0;
		nxt_i2c_sink   = 2'h0;
		for (i = 0; i < `PAD_NUM_PINS; i = i + 1) begin
			role     = cfg_ff[i][`ROLE_MSB:`ROLE_LSB];
			pull     = cfg_ff[i][`PULL_MSB:`PULL_LSB];
			i2c_mode = cfg_ff[i][`I2C_MODE_MSB:`I2C_MODE_LSB];
			// port 2 pin 0 uses alt1 for terminal-ready, alt2 for second slave select
			case (role)
				`ROLE_GPIO: begin
					drv = gpio_out_i[i];
					oe  = port_direction_reg_i[i];   // see [RULE_01] see [RULE_02]
				end
				`ROLE_ALT1: begin
					drv = alt1_out_i[i];
					oe  = alt1_oe_i[i];              // see [RULE_03] see [RULE_16]
				end
				`ROLE_ALT2: begin
					drv = alt2_out_i[i];
					oe  = alt2_oe_i[i];              // see [RULE_03] see [RULE_16]
				end
				default: begin
					// reserved codes leave the pad undriven
					drv = 1'b0;
					oe  = 1'b0;
				end
			endcase
			i2c_fn = (i == 4 || i == 5) && (role == `ROLE_ALT1);
			if (i == 4 || i == 5) begin
				// i2c pads ignore the drain bit: open-drain in i2c function, push-pull in any other function
				if (i2c_fn) begin
					nxt_pad_out[i] = 1'b0;
					nxt_pad_oe[i]  = oe & ~drv;      // see [RULE_09] see [RULE_12]
				end else begin
					nxt_pad_out[i] = drv;
					nxt_pad_oe[i]  = oe;             // see [RULE_12]
				end
				if (i2c_fn || i2c_mode != `I2C_MODE_PLAIN_IO) begin
					nxt_i2c_filter[i - 4] = (i2c_mode == `I2C_MODE_STD_FAST) ||
					                        (i2c_mode == `I2C_MODE_FAST_PLUS);   // see [RULE_09]
					nxt_i2c_sink[i - 4]   = i2c_fn && (i2c_mode == `I2C_MODE_FAST_PLUS);
				end
			end else if (cfg_ff[i][`DRAIN_BIT]) begin
				// high side off: drive only the low level
				nxt_pad_out[i] = 1'b0;
				nxt_pad_oe[i]  = oe & ~drv;          // see [RULE_11]
			end else begin
				nxt_pad_out[i] = drv;
				nxt_pad_oe[i]  = oe;                 // see [RULE_11]
			end
			case (pull)
				`PULL_DOWN: begin
					nxt_pull_dn[i] = 1'b1;           // see [RULE_04]
				end
				`PULL_UP: begin
					nxt_pull_up[i] = 1'b1;           // see [RULE_04]
				end
				`PULL_REPEATER: begin
					// keeper follows the sampled level; dropped in deep power-down
					nxt_pull_up[i] = ~dpd_sync_ff & pad_sync_ff[i];    // see [RULE_06] see [RULE_07]
					nxt_pull_dn[i] = ~dpd_sync_ff & ~pad_sync_ff[i];   // see [RULE_06] see [RULE_07]
				end
				default: begin
					nxt_pull_up[i] = 1'b0;
				end
			endcase
			nxt_schmitt[i] = cfg_ff[i][`SCHMITT_BIT];   // see [RULE_08]
		end
	end

	// serial clock source from the selected pin; other codes give a quiet low
	always @* begin
		case (sck_loc_ff)
			`SCK_LOC_P0_10: nxt_sck = pad_sync_ff[`PIN_P0_10];   // see [RULE_14]
			`SCK_LOC_P0_6:  nxt_sck = pad_sync_ff[`PIN_P0_6];    // see [RULE_14]
			default:        nxt_sck = 1'b0;
		endcase
	end

	// registered pad controls; one cycle behind configuration changes
	always @(posedge core_clk_i or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			pad_out_o                <= 25'h0000000;
			pad_oe_o                 <= 25'h0000000;
			pull_up_en_o             <= 25'h0000000;
			pull_dn_en_o             <= 25'h0000000;
			input_schmitt_enable_o   <= 25'h0000000;
			i2c_filter_en_o          <= 2'h0;
			i2c_high_sink_o          <= 2'h0;
			gpio_in_o                <= 25'h0000000;
			periph_in_o              <= 25'h0000000;
			ssp_serial_clock_input_o <= 1'b0;
		end else begin
			pad_out_o                <= nxt_pad_out;
			pad_oe_o                 <= nxt_pad_oe;
			pull_up_en_o             <= nxt_pull_up;
			pull_dn_en_o             <= nxt_pull_dn;
			input_schmitt_enable_o   <= nxt_schmitt;
			i2c_filter_en_o          <= nxt_i2c_filter;
			i2c_high_sink_o          <= nxt_i2c_sink;
			gpio_in_o                <= pad_sync_ff;
			periph_in_o              <= pad_sync_ff;
			ssp_serial_clock_input_o <= nxt_sck;
		end
	end

endmodule // pad_function_config

`default_nettype wire

// File: common/pad_config_consts.vh
// register offsets, field positions, reset values and pin indices for the pad configuration block
`ifndef PAD_CONFIG_CONSTS_VH
`define PAD_CONFIG_CONSTS_VH

`define PAD_NUM_PINS        25
`define PAD_ADDR_W          12
`define PAD_CFG_W           11

// byte offsets of the configuration space
`define OFS_RESERVED_SLOT_A          12'h004
`define OFS_PAD_CFG_PORT2_PIN0       12'h008
`define OFS_PAD_CFG_RESET_PORT0_PIN0 12'h00c
`define OFS_PAD_CFG_PORT0_PIN1       12'h010
`define OFS_PAD_CFG_PORT1_PIN8       12'h014
`define OFS_RESERVED_SLOT_B          12'h018
`define OFS_PAD_CFG_PORT0_PIN2       12'h01c
`define OFS_PAD_CFG_PORT0_PIN3       12'h02c
`define OFS_PAD_CFG_PORT0_PIN4       12'h030
`define OFS_PAD_CFG_PORT0_PIN5       12'h034
`define OFS_PAD_CFG_PORT1_PIN9       12'h038
`define OFS_PAD_CFG_PORT3_PIN4       12'h03c
`define OFS_PAD_CFG_PORT3_PIN5       12'h048
`define OFS_PAD_CFG_PORT0_PIN6       12'h04c
`define OFS_PAD_CFG_PORT0_PIN7       12'h050
`define OFS_PAD_CFG_PORT0_PIN8       12'h060
`define OFS_PAD_CFG_PORT0_PIN9       12'h064
`define OFS_PAD_CFG_DEBUGCLK_P0_PIN10 12'h068
`define OFS_PAD_CFG_PORT1_PIN1       12'h07c
`define OFS_PAD_CFG_PORT1_PIN2       12'h080
`define OFS_PAD_CFG_DEBUGIO_P1_PIN3  12'h090
`define OFS_PAD_CFG_PORT1_PIN4       12'h094
`define OFS_PAD_CFG_PORT1_PIN11      12'h098
`define OFS_PAD_CFG_PORT3_PIN2       12'h09c
`define OFS_PAD_CFG_PORT1_PIN5       12'h0a0
`define OFS_PAD_CFG_PORT1_PIN6       12'h0a4
`define OFS_PAD_CFG_PORT1_PIN7       12'h0a8
`define OFS_SERIAL_CLOCK_LOC_SELECT  12'h0b0

// field positions inside a pin register
`define ROLE_LSB            0
`define ROLE_MSB            2
`define PULL_LSB            3
`define PULL_MSB            4
`define SCHMITT_BIT         5
`define I2C_MODE_LSB        8
`define I2C_MODE_MSB        9
`define DRAIN_BIT           10

// encodings
`define ROLE_GPIO           3'h0
`define ROLE_ALT1           3'h1
`define ROLE_ALT2           3'h2
`define PULL_NONE           2'h0
`define PULL_DOWN           2'h1
`define PULL_UP             2'h2
`define PULL_REPEATER       2'h3
`define I2C_MODE_STD_FAST   2'h0
`define I2C_MODE_PLAIN_IO   2'h1
`define I2C_MODE_FAST_PLUS  2'h2

// reset values and write masks
`define RST_PAD_CFG         11'h0d0
`define RST_PAD_CFG_I2C     11'h000
`define RST_SCK_LOC         2'h0
`define WR_MASK_PAD_CFG     11'h43f
`define WR_MASK_PAD_CFG_I2C 11'h73f

// pin indices (ordered by port number)
`define PIN_P0_4            5'd4
`define PIN_P0_5            5'd5
`define PIN_P0_6            5'd6
`define PIN_P0_10           5'd10
`define PIN_P2_0            5'd21
`define PIN_NONE            5'd31

// serial clock location codes
`define SCK_LOC_P0_10       2'h0
`define SCK_LOC_P0_6        2'h1

`endif

// File: tb/pad_function_config_sva.sv
// assertion checker for the pad configuration block
`timescale 1ns/100ps
`default_nettype none
module pad_function_config_sva (
	input wire logic        core_clk_i,               // clock
	input wire logic        rst_b_i,                  // reset, active low
	input wire logic [11:0] reg_addr_i,               // offset
	input wire logic [31:0] reg_wdata_i,              // write data
	input wire logic        reg_wr_i,                 // write strobe
	input wire logic        reg_rd_i,                 // read strobe
	input wire logic [31:0] reg_rdata_o,              // read data
	input wire logic [24:0] pad_in_i,                 // raw pads
	input wire logic [24:0] gpio_in_o,                // synced to gpio
	input wire logic [24:0] periph_in_o,              // synced to peripherals
	input wire logic        ssp_serial_clock_input_o, // routed clock
	input wire logic [24:0] pull_up_en_o,             // pull-ups
	input wire logic [24:0] pull_dn_en_o,             // pull-downs
	input wire logic [1:0]  i2c_filter_en_o,          // glitch filters
	input wire logic [1:0]  i2c_high_sink_o           // high sinks
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [2:0] up_cnt_ff;
	// sync paths are judged only once reset release and the sync chain have flushed
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			up_cnt_ff <= 3'h0;
		else if (up_cnt_ff != 3'h7)
			up_cnt_ff <= up_cnt_ff + 3'h1;
	end
	sequence s_wr_pin1;
		reg_wr_i && reg_addr_i == 12'h010;
	endsequence
	sequence s_rd_pin1;
		reg_rd_i && reg_addr_i == 12'h010;
	endsequence
	property p_readback;
		s_wr_pin1 ##2 s_rd_pin1 |=> (reg_rdata_o & 32'h43f) == ($past(reg_wdata_i, 3) & 32'h43f);
	endproperty
	a_readback: assert property (p_readback) else $error("stored bits not read back");
	property p_rd_idle;
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
	property p_hi_zero;
		reg_rd_i |=> reg_rdata_o[31:11] == 21'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits not zero");
	property p_rsvd;
		reg_rd_i && (reg_addr_i == 12'h004 || reg_addr_i == 12'h018 || reg_addr_i == 12'h0c0) |=> reg_rdata_o == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("unassigned offset not zero");
	property p_fixed_bits;
		reg_rd_i && reg_addr_i inside {12'h008, 12'h010, 12'h0a8} |=> reg_rdata_o[9:6] == 4'h3;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("bits 9:6 not 0011");
	property p_pull_excl;
		(pull_up_en_o & pull_dn_en_o) == 25'h0;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on one pin");
	property p_sync;
		up_cnt_ff == 3'h7 |-> gpio_in_o == $past(pad_in_i, 3) && periph_in_o == gpio_in_o;
	endproperty
	a_sync: assert property (p_sync) else $error("input path latency wrong");
	property p_sck_src;
		up_cnt_ff == 3'h7 && ssp_serial_clock_input_o |-> $past(pad_in_i[10], 3) || $past(pad_in_i[6], 3);
	endproperty
	a_sck_src: assert property (p_sck_src) else $error("serial clock from no location");
	property p_sink_filter;
		(i2c_high_sink_o & ~i2c_filter_en_o) == 2'h0;
	endproperty
	a_sink_filter: assert property (p_sink_filter) else $error("sink without filter");
endmodule // pad_function_config_sva
`default_nettype wire

// File: tb/test_pad_function_config.sv
// self-checking bench for the pad configuration block
`timescale 1ns/100ps
`default_nettype none
module test_pad_function_config;
	localparam logic [24:0] all_pins = 25'h1ffffff;
	logic        clk = 1'b0, rstb = 1'b0, wr = 1'b0, rd = 1'b0, dpd = 1'b0, sck;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [24:0] dir = 25'h0, gout = 25'h0, pin = 25'h0, a1o = 25'h0, a1e = 25'h0, a2o = 25'h0, a2e = 25'h0;
	logic [24:0] gin, pdi, pout, poe, pup, pdn, sch;
	logic [1:0]  filt, sink;
	int          fails = 0, checks_done = 0;
	pad_function_config uut (
		.core_clk_i(clk), .rst_b_i(rstb), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .port_direction_reg_i(dir), .gpio_out_i(gout), .gpio_in_o(gin), .alt1_out_i(a1o),
		.alt1_oe_i(a1e), .alt2_out_i(a2o), .alt2_oe_i(a2e), .periph_in_o(pdi), .ssp_serial_clock_input_o(sck),
		.pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .pull_up_en_o(pup), .pull_dn_en_o(pdn),
		.input_schmitt_enable_o(sch), .i2c_filter_en_o(filt), .i2c_high_sink_o(sink), .deep_powerdown_i(dpd)
	);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic wreg(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// pad inputs cross a sync chain, so leave room beyond its three edges
	task automatic settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic t_reset;
		logic [7:0] ofs [$] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h2c, 8'h30, 8'h34, 8'h38,
			8'h3c, 8'h48, 8'h4c, 8'h50, 8'h60, 8'h64, 8'h68, 8'h7c, 8'h80, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0,
			8'ha4, 8'ha8, 8'hb0, 8'hc0};
		foreach (ofs[i]) begin
			rreg({4'h0, ofs[i]}, d);
			chk_w(d, (ofs[i] inside {8'h04, 8'h18, 8'h30, 8'h34, 8'hb0, 8'hc0}) ? 32'h0 : 32'hd0);
		end
		chk_w(32'(pup), 32'h1ffffcf);
		chk_w(32'(sch), 32'h0);
		chk_w({30'h0, filt}, 32'h3);
	endtask
	task automatic t_regs;
		logic [11:0] a [4] = '{12'h010, 12'h030, 12'h004, 12'h0b0};
		logic [31:0] e [4] = '{32'h4ff, 32'h73f, 32'h0, 32'h3};
		foreach (a[i]) begin
			wreg(a[i], 32'hffffffff);
			rreg(a[i], d);
			chk_w(d, e[i]);
		end
		// a register that was never written must keep its own reset value
		rreg(12'h014, d);
		chk_w(d, 32'hd0);
	endtask
	task automatic t_gpio;
		@(posedge clk);
		dir <= 25'h2;
		gout <= 25'h2;
		wreg(12'h010, 32'h0);
		settle;
		chk_b(poe[1] & pout[1], 1'b1);
		@(posedge clk);
		dir <= 25'h0;
		settle;
		chk_b(poe[1], 1'b0);
		@(posedge clk);
		dir <= 25'h2;
		wreg(12'h010, 32'h400);
		settle;
		chk_b(poe[1], 1'b0);
		@(posedge clk);
		gout <= 25'h0;
		settle;
		chk_b(poe[1] & ~pout[1], 1'b1);
	endtask
	task automatic t_periph;
		@(posedge clk);
		dir <= 25'h0;
		a1e <= all_pins;
		a1o <= all_pins;
		wreg(12'h008, 32'h1);
		settle;
		chk_b(poe[21] & pout[21], 1'b1);
		@(posedge clk);
		dir <= all_pins;
		wreg(12'h008, 32'h2);
		settle;
		chk_b(poe[21], 1'b0);
		@(posedge clk);
		a2e <= all_pins;
		for (int c = 3; c < 8; c++) begin
			wreg(12'h008, 32'(c));
			settle;
			chk_b(poe[21], 1'b0);
		end
		// second slave select now drives low with its enable up
		wreg(12'h008, 32'h2);
		settle;
		chk_b(poe[21] & ~pout[21], 1'b1);
	endtask
	task automatic t_pull;
		for (int m = 0; m < 3; m++) begin
			wreg(12'h010, 32'(m << 3) | 32'h20);
			settle;
			chk_b(pup[1], m == 2);
			chk_b(pdn[1], m == 1);
		end
		chk_b(sch[1], 1'b1);
		@(posedge clk);
		pin <= 25'h2;
		wreg(12'h010, 32'h18);
		settle;
		chk_b(pup[1] & ~pdn[1], 1'b1);
		@(posedge clk);
		pin <= 25'h0;
		settle;
		chk_b(pdn[1] & ~pup[1], 1'b1);
		@(posedge clk);
		dpd <= 1'b1;
		settle;
		chk_b(pdn[1], 1'b0);
		@(posedge clk);
		dpd <= 1'b0;
	endtask
	task automatic t_i2c;
		for (int i = 0; i < 3; i++) begin
			wreg(12'h030, 32'h1 | (32'(i) << 8));
			settle;
			chk_b(filt[0], i != 1);
			chk_b(sink[0], i == 2);
		end
		wreg(12'h030, 32'h001);
		settle;
		chk_b(poe[4], 1'b0);
		@(posedge clk);
		gout <= all_pins;
		// gpio use of an i2c pin ignores the drain bit and drives push-pull
		wreg(12'h030, 32'h400);
		settle;
		chk_b(poe[4] & pout[4], 1'b1);
	endtask
	task automatic t_sck;
		@(posedge clk);
		pin <= 25'h400;
		wreg(12'h0b0, 32'h0);
		settle;
		chk_b(sck, 1'b1);
		wreg(12'h0b0, 32'h1);
		settle;
		chk_b(sck, 1'b0);
		@(posedge clk);
		pin <= 25'h40;
		settle;
		chk_b(sck, 1'b1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstb <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_regs;
		t_gpio;
		t_periph;
		t_pull;
		t_i2c;
		t_sck;
		stop_test;
	end
	// the sequence needs under 2000 cycles, so 20000 only trips on a hang
	initial begin
		#200000;
		fails++;
		stop_test;
	end
endmodule // test_pad_function_config
bind pad_function_config pad_function_config_sva u_sva (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .pad_in_i, .gpio_in_o, .periph_in_o, .ssp_serial_clock_input_o,
	.pull_up_en_o, .pull_dn_en_o, .i2c_filter_en_o, .i2c_high_sink_o);
`default_nettype wire
